// >>> gpfw_master.sv
// Purpose: Port clock source of the graphics master.
// Assumes: Clock runs only while a fast write is in flight.
// Notes: The clock rests low between transfers.
`timescale 1ns/1ps
`default_nettype none
module gpfw_master (
   input  wire logic run,
   output var  logic port_clk
);
   initial port_clk = 1'b0;
   always #100 port_clk = run ? ~port_clk : 1'b0;
endmodule : gpfw_master
`default_nettype wire

// >>> gpfw_pkg.sv
// Purpose: Shared constants for the graphics port target and fast-write slice.
// Assumes: APB register access, 32-bit data, one word per register.
// Notes: Offsets, field positions and command codes live here; the checker spells the codes out as literals.
package gpfw_pkg;
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_COUNT  = 8'h08;
   localparam logic [7:0] OFF_STATE  = 8'h0c;
   localparam int RATE_1X_BIT = 0;
   localparam int RATE_2X_BIT = 1;
   localparam int RATE_4X_BIT = 2;
   localparam int FWE_BIT     = 4;
   localparam int LOCK_BIT    = 8;
   localparam logic [31:0] CMD_RESET    = 32'h0000_0000;
   localparam logic [31:0] STATUS_VALUE = 32'h0000_0017;
   localparam logic [3:0] C_READ     = 4'h0;
   localparam logic [3:0] C_READ_HI  = 4'h1;
   localparam logic [3:0] C_WRITE    = 4'h4;
   localparam logic [3:0] C_WRITE_HI = 4'h5;
   localparam logic [3:0] C_LREAD    = 4'h8;
   localparam logic [3:0] C_LREAD_HI = 4'h9;
   localparam logic [3:0] C_FLUSH    = 4'ha;
   localparam logic [3:0] C_FENCE    = 4'hc;
   localparam int BLOCK_CLOCKS = 4;
   localparam int BYTES_4X     = 16;
   localparam logic [2:0] RATE_1X = 3'h1;
   localparam logic [2:0] RATE_2X = 3'h2;
   localparam logic [2:0] RATE_4X = 3'h4;
   localparam logic [31:0] FILL_DATA = 32'hdead_beef;
   typedef enum logic [3:0] {
      GPFW_IDLE  = 4'b0001,
      GPFW_SYNC  = 4'b0010,
      GPFW_BLOCK = 4'b0100,
      GPFW_GAP   = 4'b1000
   } gpfw_state_t;
endpackage : gpfw_pkg

// >>> gpfw_sva.sv
// Purpose: Port checker for the graphics port slice.
// Assumes: One clock domain, bound to gpfw_top.
// Notes: Only the ports that the properties need are taken.
`timescale 1ns/1ps
`default_nettype none
module gpfw_sva (
   input wire logic        pclk, presetn, req_valid, req_to_hub, req_frame,
   input wire logic [3:0]  req_cmd,
   input wire logic        mem_valid, mem_hi_prio, mem_be_on, mem_snoop,
   input wire logic        mem_fence, local_valid, frame_abort, fw_done,
   input wire logic        fw_b2b,
   input wire logic [1:0]  fw_mode,
   input wire logic [63:0] local_data
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic enh;
   logic hub;
   assign enh = req_valid && !req_frame;
   assign hub = req_to_hub;
   property p_rd_hi;
      enh && !hub && req_cmd inside {4'h1, 4'h9} |=> mem_valid && mem_hi_prio;
   endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("hi read");
   property p_rd_hub;
      enh && hub && req_cmd inside {4'h0, 4'h1, 4'h8, 4'h9}
      |=> local_valid && !mem_valid;
   endproperty
   a_rd_hub: assert property (p_rd_hub) else $error("hub read");
   property p_wr_hub;
      enh && hub && req_cmd inside {4'h4, 4'h5} |=> mem_valid && !mem_be_on;
   endproperty
   a_wr_hub: assert property (p_wr_hub) else $error("hub write");
   property p_flush;
      enh && req_cmd == 4'ha
      |=> local_valid && local_data == {2{gpfw_pkg::FILL_DATA}};
   endproperty
   a_flush: assert property (p_flush) else $error("flush");
   property p_fence;
      enh && req_cmd == 4'hc |=> mem_fence && !mem_valid && !local_valid;
   endproperty
   a_fence: assert property (p_fence) else $error("fence");
   property p_rsvd;
      enh && req_cmd inside {4'h2, 4'h3, 4'h6, 4'h7, 4'hb, 4'hd, 4'he, 4'hf}
      |=> !mem_valid && !local_valid && !mem_fence;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved");
   property p_snoop;
      req_valid |=> !mem_valid || mem_snoop == $past(req_frame);
   endproperty
   a_snoop: assert property (p_snoop) else $error("snoop");
   property p_abort;
      req_valid && req_frame && hub |=> frame_abort && !mem_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("abort");
   property p_b2b;
      fw_mode == 2'h0 |-> !fw_b2b;
   endproperty
   a_b2b: assert property (p_b2b) else $error("b2b at 1x");
   c_done: cover property (fw_done);
   c_local: cover property (local_valid);
   c_abort: cover property (frame_abort);
endmodule : gpfw_sva
bind gpfw_top gpfw_sva u_gpfw_sva (.*);
`default_nettype wire

// >>> gpfw_top.sv
// Purpose: Command decode and fast-write path of the graphics port slice.
// Assumes: pclk 40 MHz; port clock is a plain pin sampled by pclk.
// Notes: Registers sit on APB; the rate is latched once and then frozen.
//
// Summary of operation
// - Reads 0000/1000 go low priority, 0001/1001 high priority.
// - Enhanced reads aimed at the I/O hub complete locally with fill data.
// - Writes 0100/0101 keep priority; hub-aimed ones go with byte enables off.
// - Flush 1010 completes locally returning one quadword of fill data.
// - Fence 1100 gives no data and queues an ordering marker.
// - Pipelined or sideband accesses to memory never snoop.
// - Frame-protocol memory accesses from the master always snoop.
// - Frame accesses to the I/O hub are refused; hub writes pass.
// - Device never initiates enhanced-protocol cycles, only targets them.
// - Pipelined and frame requests may interleave freely.
// - Status register bit 2 advertises 4x capability.
// - Rate latched at initialisation and then never changes.
// - 4x moves 16 bytes per port clock edge, same control protocol.
// - Throttle block is four port clocks, 64 bytes at 4x.
// - 4x adds two data and one sideband complementary strobes.
// - No back-to-back cycles at 1x; allowed in 2x and 4x fast writes.
// - Fast writes only with fast_write_enable set; else 1x protocol.
// - Host and hub memory writes use fast writes when enabled.
// - Fast writes strobe at 4x with rate bit 2, 2x with bit 1.
// - Rate bit 0 disables fast writes, standard protocol used.
`timescale 1ns/1ps
`default_nettype none
module gpfw_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        req_valid,
   input  wire logic [3:0]  req_cmd,
   input  wire logic        req_to_hub,
   input  wire logic        req_frame,
   output logic             mem_valid,
   output logic             mem_write,
   output logic             mem_hi_prio,
   output logic             mem_be_on,
   output logic             mem_snoop,
   output logic             mem_fence,
   output logic             local_valid,
   output logic      [63:0] local_data,
   output logic             frame_abort,
   input  wire logic        fw_req,
   input  wire logic        port_clk,
   output logic             fw_busy,
   output logic             fw_done,
   output logic      [1:0]  fw_mode,
   output logic             fw_b2b,
   output logic             ad_stb,
   output logic      [1:0]  ad_stb_n,
   output logic             sba_stb_n,
   output logic      [7:0]  fw_bytes
);
   logic [31:0] cmd_reg;
   logic        locked_reg;
   logic [15:0] count_reg;
   logic [2:0]  pc_sync_reg;
   logic        pc_edge;
   logic        rd;
   logic [2:0]  rate;
   logic        fw_on;
   logic [1:0]  blk_reg;
   logic        pend_reg;
   gpfw_pkg::gpfw_state_t state_reg;

   // Register bus.
   // The slave answers every access one cycle after its setup cycle.
   // Read data is captured during the setup cycle and stands in the access.
   // An unmapped address raises the error flag together with ready.
   // Writes land only at the edge where ready is seen high.
   // Writes to the command word are dropped once the lock bit is set.
   // The lock bit can only be cleared again by a reset.
   // Only the rate bits, the fast-write enable and the lock bit are kept.
   // All other command bits read back as zero.
   // The status word is a constant and advertises every rate.
   // The block counter wraps silently after its last value.
   // The state word shows the busy flag and the one-hot state.

   // Target requests.
   // Every request is decoded in the cycle it is presented.
   // Exactly one answer pulse follows one cycle later for every frame request and for every pipelined code except the reserved ones.
   // Memory attributes hold their last value between requests.
   // They are only meaningful while the memory strobe is high.
   // Frame-protocol requests are kept apart from pipelined ones.
   // Frame requests to memory always ask for a cache snoop.
   // Pipelined and sideband requests never ask for a snoop.
   // Frame requests to the I/O hub are refused with an abort pulse.
   // Enhanced reads aimed at the hub never leave this block.
   // They complete at once with the fill pattern.
   // Enhanced writes aimed at the hub still reach memory.
   // Their byte enables are switched off so memory is left intact.
   // A flush returns one quadword of the fill pattern.
   // A fence only raises the ordering marker for the request queue.
   // Reserved codes in pipelined requests leave every answer output low.
   // Requests may arrive on consecutive cycles in any mix.
   // The block never starts an enhanced-protocol cycle by itself.

   // Port clock.
   // The port clock comes from outside and is not related to pclk.
   // It passes two flip-flops before any logic reads it.
   // A third stage is kept only to find its edges.
   // The port clock must stay well below half the pclk rate.
   // Each port clock level must last at least two pclk periods.
   // Otherwise edges are lost and a block takes longer to finish.

   // Fast writes.
   // A request toward the graphics master may come at any cycle.
   // One further request is remembered while a block is in flight.
   // A block starts on the next rising port clock edge.
   // It lasts four rising port clock edges, the throttle unit.
   // The done pulse marks the end of every block.
   // With fast writes on, a waiting request follows with no gap.
   // That chained block is flagged as back to back.
   // With fast writes off, one port clock edge separates blocks.
   // The busy flag stays high for the whole of a chained run.
   // The master model only runs the port clock while busy is high.
   // A gap state therefore ends on the falling edge after busy drops.

   // Rate selection.
   // The rate and the enable come from the command word.
   // They are meant to be set once and then locked.
   // Fast writes need the enable and a 2x or 4x rate bit.
   // The 1x rate bit alone turns fast writes off.
   // Settings with several rate bits are treated as fast writes off.
   // The mode output reads 0 for 1x, 1 for 2x and 2 for 4x.

   // Strobes.
   // The data strobe follows the synchronised port clock in a 2x or 4x block and stays low at 1x.
   // At 4x the complementary strobes run opposite to it.
   // The complementary strobes rest high outside 4x blocks.
   // The byte count shows what moves on each port clock edge.
   // It is 16 at 4x, 8 at 2x and 4 for the 1x protocol.
   // It reads zero while no block is in flight.
   // Strobe outputs lag the port clock by the synchroniser delay.

   // Reset.
   // Reset is asynchronous and active low.
   // Every output leaves reset low except the idle-high strobes.
   // The command word returns to zero and the lock is released.
   // A pending fast-write request is lost on reset.
   // The first bus access may start at the first edge after reset.

   // Limits.
   // There is no buffering of request data in this slice.
   // The fill pattern is fixed and carries no meaning.
   // The block counter is only a debugging aid.
   // Software must set exactly one rate bit before locking.
   // Nothing here checks that the master keeps the throttle unit.
   // The ordering marker is a single pulse and is not stored.
   // Downstream logic must queue it with the memory requests.
   // Back-to-back output is a level valid during the chained block.
   // It falls when the run ends or the block returns to idle.
   // The sideband strobe shares the timing of the data strobes.
   // No interrupt is raised by any event in this slice.
   // Error flags other than the bus error are not provided.
   // All outputs come straight from flip-flops.

   assign rd      = psel && penable && !pwrite;
   assign rate    = cmd_reg[gpfw_pkg::RATE_4X_BIT:gpfw_pkg::RATE_1X_BIT];
   // Fast writes need the enable and a 2x or 4x rate.
   assign fw_on   = cmd_reg[gpfw_pkg::FWE_BIT] &&
                    (rate == gpfw_pkg::RATE_2X ||
                     rate == gpfw_pkg::RATE_4X);
   assign pc_edge = pc_sync_reg[2] ^ pc_sync_reg[1];

   // APB slave answers in the access cycle, no wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable &&
                    !(paddr == gpfw_pkg::OFF_CMD ||
                      paddr == gpfw_pkg::OFF_STATUS ||
                      paddr == gpfw_pkg::OFF_COUNT ||
                      paddr == gpfw_pkg::OFF_STATE);
         if (psel && !penable && !pwrite) begin
            case (paddr)
               gpfw_pkg::OFF_CMD:    prdata <= cmd_reg;
               gpfw_pkg::OFF_STATUS: prdata <= gpfw_pkg::STATUS_VALUE;
               gpfw_pkg::OFF_COUNT:  prdata <= {16'h0000, count_reg};
               gpfw_pkg::OFF_STATE:  prdata <= {27'h0, fw_busy, state_reg};
               default:              prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Command register; the lock bit freezes the rate and enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_reg    <= gpfw_pkg::CMD_RESET;
         locked_reg <= 1'b0;
      end else if (psel && penable && pready && pwrite &&
                   paddr == gpfw_pkg::OFF_CMD && !locked_reg) begin
         cmd_reg    <= pwdata & 32'h0000_0117;
         locked_reg <= pwdata[gpfw_pkg::LOCK_BIT];
      end
   end

   // Decode of target requests; the device only answers, never initiates.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_valid   <= 1'b0;
         mem_write   <= 1'b0;
         mem_hi_prio <= 1'b0;
         mem_be_on   <= 1'b0;
         mem_snoop   <= 1'b0;
         mem_fence   <= 1'b0;
         local_valid <= 1'b0;
         local_data  <= 64'h0;
         frame_abort <= 1'b0;
      end else begin
         mem_valid   <= 1'b0;
         mem_fence   <= 1'b0;
         local_valid <= 1'b0;
         frame_abort <= 1'b0;
         if (req_valid && req_frame) begin
            if (req_to_hub) begin
               frame_abort <= 1'b1;
            end else begin
               mem_valid   <= 1'b1;
               mem_write   <= req_cmd[0];
               mem_hi_prio <= 1'b0;
               mem_be_on   <= 1'b1;
               mem_snoop   <= 1'b1;
            end
         end else if (req_valid) begin
            case (req_cmd)
               gpfw_pkg::C_READ, gpfw_pkg::C_READ_HI,
               gpfw_pkg::C_LREAD, gpfw_pkg::C_LREAD_HI: begin
                  if (req_to_hub) begin
                     local_valid <= 1'b1;
                     local_data  <= {2{gpfw_pkg::FILL_DATA}};
                  end else begin
                     mem_valid   <= 1'b1;
                     mem_write   <= 1'b0;
                     mem_hi_prio <= req_cmd[0];
                     mem_be_on   <= 1'b1;
                     mem_snoop   <= 1'b0;
                  end
               end
               gpfw_pkg::C_WRITE, gpfw_pkg::C_WRITE_HI: begin
                  mem_valid   <= 1'b1;
                  mem_write   <= 1'b1;
                  mem_hi_prio <= req_cmd[0];
                  mem_be_on   <= !req_to_hub;
                  mem_snoop   <= 1'b0;
               end
               gpfw_pkg::C_FLUSH: begin
                  local_valid <= 1'b1;
                  local_data  <= {2{gpfw_pkg::FILL_DATA}};
               end
               gpfw_pkg::C_FENCE: begin
                  mem_fence <= 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Port clock passes two flip-flops; the third stage finds edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_sync_reg <= 3'h0;
      end else begin
         pc_sync_reg <= {pc_sync_reg[1:0], port_clk};
      end
   end

   // Host and hub writes toward the master, in blocks of four port clocks.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= gpfw_pkg::GPFW_IDLE;
         blk_reg   <= 2'h0;
         pend_reg  <= 1'b0;
         fw_busy   <= 1'b0;
         fw_done   <= 1'b0;
         fw_b2b    <= 1'b0;
         count_reg <= 16'h0;
      end else begin
         fw_done <= 1'b0;
         if (fw_req) begin
            pend_reg <= 1'b1;
         end
         case (state_reg)
            gpfw_pkg::GPFW_IDLE: begin
               fw_b2b <= 1'b0;
               if (fw_req || pend_reg) begin
                  pend_reg  <= 1'b0;
                  fw_busy   <= 1'b1;
                  state_reg <= gpfw_pkg::GPFW_SYNC;
               end
            end
            gpfw_pkg::GPFW_SYNC: begin
               if (pc_edge && pc_sync_reg[1]) begin
                  blk_reg   <= 2'h0;
                  state_reg <= gpfw_pkg::GPFW_BLOCK;
               end
            end
            gpfw_pkg::GPFW_BLOCK: begin
               if (pc_edge && pc_sync_reg[1]) begin
                  blk_reg <= blk_reg + 2'h1;
                  if (blk_reg == 2'(gpfw_pkg::BLOCK_CLOCKS - 1)) begin
                     count_reg <= count_reg + 16'h1;
                     fw_done   <= 1'b1;
                     if (fw_on && (pend_reg || fw_req)) begin
                        pend_reg  <= 1'b0;
                        fw_b2b    <= 1'b1;
                        blk_reg   <= 2'h0;
                     end else begin
                        fw_b2b    <= 1'b0;
                        fw_busy   <= 1'b0;
                        state_reg <= fw_on ? gpfw_pkg::GPFW_IDLE
                                           : gpfw_pkg::GPFW_GAP;
                     end
                  end
               end
            end
            gpfw_pkg::GPFW_GAP: begin
               if (pc_edge) begin
                  state_reg <= gpfw_pkg::GPFW_IDLE;
               end
            end
            default: state_reg <= gpfw_pkg::GPFW_IDLE;
         endcase
      end
   end

   // Strobes and byte counts follow the frozen rate.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fw_mode   <= 2'h0;
         ad_stb    <= 1'b0;
         ad_stb_n  <= 2'h3;
         sba_stb_n <= 1'b1;
         fw_bytes  <= 8'h0;
      end else begin
         fw_mode <= !fw_on ? 2'h0 :
                    rate[gpfw_pkg::RATE_4X_BIT] ? 2'h2 : 2'h1;
         if (state_reg == gpfw_pkg::GPFW_BLOCK) begin
            ad_stb <= fw_on ? pc_sync_reg[1] : 1'b0;
            if (fw_on && rate[gpfw_pkg::RATE_4X_BIT]) begin
               ad_stb_n  <= {2{!pc_sync_reg[1]}};
               sba_stb_n <= !pc_sync_reg[1];
               fw_bytes  <= 8'(gpfw_pkg::BYTES_4X);
            end else begin
               ad_stb_n  <= 2'h3;
               sba_stb_n <= 1'b1;
               fw_bytes  <= fw_on ? 8'h08 : 8'h04;
            end
         end else begin
            ad_stb    <= 1'b0;
            ad_stb_n  <= 2'h3;
            sba_stb_n <= 1'b1;
            fw_bytes  <= 8'h0;
         end
      end
   end

   // A setting with more than one rate bit is the software's fault.
   logic unused_ok;
   assign unused_ok = rd | (|pwdata[31:9]) | (|cmd_reg[31:9]);
endmodule : gpfw_top
`default_nettype wire

// >>> gpfw_top_tb.sv
// Purpose: Self-checking bench for the graphics port slice.
// Assumes: APB master on pclk, port clock from the master model.
// Notes: Each scenario is a task of its own.
`timescale 1ns/1ps
`default_nettype none
module gpfw_top_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, req_valid = 0, req_to_hub = 0, req_frame = 0;
   logic [3:0] req_cmd = '0;
   logic mem_valid, mem_write, mem_hi_prio, mem_be_on, mem_snoop, e;
   logic mem_fence, local_valid, frame_abort, fw_req = 0, port_clk;
   logic fw_busy, fw_done, fw_b2b, ad_stb, sba_stb_n;
   logic [63:0] local_data;
   logic [1:0] fw_mode, ad_stb_n;
   logic [7:0] fw_bytes;
   int error_cnt = 0, compares = 0;
   always #12.5 pclk = ~pclk;
   gpfw_top u_gpfw_top (.*);
   gpfw_master u_gpfw_master (.run(fw_busy), .port_clk(port_clk));
   task automatic chk(string n, logic [63:0] x, logic [63:0] g);
      compares++;
      if (g !== x) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", n, x, g);
      end
   endtask : chk
   task automatic results;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results
   task automatic rst;
      presetn <= 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
   endtask : rst
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      rd = prdata;
      e = pslverr;
      if (pready !== 1'b1) begin
         error_cnt++;
         results();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic req(logic [3:0] c, logic h, logic f);
      @(posedge pclk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_to_hub <= h;
      req_frame <= f;
      @(posedge pclk);
      req_valid <= 1'b0;
      @(negedge pclk);
   endtask : req
   task automatic t_regs;
      apb(1'b0, gpfw_pkg::OFF_STATUS, '0);
      chk("status", gpfw_pkg::STATUS_VALUE, rd);
      apb(1'b0, gpfw_pkg::OFF_CMD, '0);
      chk("cmd", gpfw_pkg::CMD_RESET, rd);
      apb(1'b0, 8'h10, '0);
      chk("unmapped", 1'b1, e);
   endtask : t_regs
   task automatic t_cmds;
      logic r, w, hi;
      for (int i = 0; i < 32; i++) begin
         r = i[3:0] inside {4'h0, 4'h1, 4'h8, 4'h9};
         w = i[3:0] inside {4'h4, 4'h5};
         hi = i[3:0] inside {4'h1, 4'h5, 4'h9};
         req(i[3:0], i[4], 1'b0);
         chk("resp", {r & !i[4] | w, r & i[4] | i[3:0] == 4'ha,
             i[3:0] == 4'hc, 1'b0},
             {mem_valid, local_valid, mem_fence, frame_abort});
         if (r & !i[4] | w)
            chk("attr", {w, hi, 1'b0}, {mem_write, mem_hi_prio, mem_snoop});
         if (w) chk("be", !i[4], mem_be_on);
         if (i[3:0] == 4'ha)
            chk("fill", {2{gpfw_pkg::FILL_DATA}}, local_data);
      end
   endtask : t_cmds
   task automatic t_frame;
      req(gpfw_pkg::C_READ, 1'b0, 1'b1);
      chk("fsnoop", 2'b11, {mem_valid, mem_snoop});
      req(gpfw_pkg::C_READ, 1'b1, 1'b1);
      chk("fabort", 2'b10, {frame_abort, mem_valid});
      @(posedge pclk);
      req_valid <= 1'b1;
      req_cmd <= gpfw_pkg::C_READ_HI;
      req_to_hub <= 1'b0;
      req_frame <= 1'b0;
      @(posedge pclk);
      req_frame <= 1'b1;
      @(negedge pclk);
      chk("mix1", 3'b110, {mem_valid, mem_hi_prio, mem_snoop});
      @(posedge pclk);
      req_valid <= 1'b0;
      @(negedge pclk);
      chk("mix2", 2'b11, {mem_valid, mem_snoop});
   endtask : t_frame
   task automatic t_fw(logic [31:0] c, logic [1:0] m);
      logic b, s;
      int n, d;
      b = 0;
      s = 0;
      n = 0;
      d = 0;
      rst();
      apb(1'b1, gpfw_pkg::OFF_CMD, c);
      apb(1'b1, gpfw_pkg::OFF_CMD, c ^ 32'h0000_0007);
      apb(1'b0, gpfw_pkg::OFF_CMD, '0);
      chk("frozen", c, rd);
      repeat (2) begin
         @(posedge pclk);
         fw_req <= 1'b1;
         @(posedge pclk);
         fw_req <= 1'b0;
      end
      while (d < 2 && n < 2000) begin
         @(negedge pclk);
         n++;
         d += (fw_done === 1'b1);
         b |= (fw_b2b === 1'b1);
         s |= (ad_stb_n !== 2'b11);
         if (fw_bytes !== 8'h00)
            chk("bytes", m == 2 ? 16 : m == 1 ? 8 : 4, fw_bytes);
      end
      if (d < 2) begin
         error_cnt++;
         results();
      end
      chk("mode", m, fw_mode);
      chk("b2b", m != 0, b);
      chk("stb", m == 2, s);
   endtask : t_fw
   initial begin
      rst();
      t_regs();
      t_cmds();
      t_frame();
      t_fw(32'h0000_0114, 2'h2);
      t_fw(32'h0000_0112, 2'h1);
      t_fw(32'h0000_0111, 2'h0);
      t_fw(32'h0000_0104, 2'h0);
      results();
   end
endmodule : gpfw_top_tb
`default_nettype wire
